/* hw/halt_pkg.sv */
// shared constants and types for the halt sequencer and trim correction
package halt_pkg;
    // -------------------------------------------------------------------
    // clock and timing
    // -------------------------------------------------------------------
    localparam int unsigned CLK_HZ         = 125_000_000;
    localparam int unsigned HALT_TIMEOUT_S = 5;
    localparam int unsigned HALT_CYC       = CLK_HZ * HALT_TIMEOUT_S;

    // -------------------------------------------------------------------
    // widths
    // -------------------------------------------------------------------
    localparam int LEN_W = 24;
    localparam int PCT_W = 24;
    localparam int AGE_W = 8;
    localparam int TMR_W = 30;

    // -------------------------------------------------------------------
    // reset values
    // -------------------------------------------------------------------
    // 100.000 percent, three decimal places
    localparam logic [PCT_W-1:0] SCALE_UNITY = 24'h0186A0;

    // -------------------------------------------------------------------
    // types
    // -------------------------------------------------------------------
    typedef enum logic [1:0] {ST_IDLE, ST_RUN, ST_PRESS, ST_DECEL} seq_state_t;
endpackage

/* hw/trim_div.sv */
// serial restoring divider for the correction factor
`timescale 1ns/1ps
module trim_div #(
    parameter int W = 48
) (
    // clock and reset
    input  wire logic         clock,
    input  wire logic         rst_n,
    // request
    input  wire logic         start,
    input  wire logic [W-1:0] num,
    input  wire logic [W-1:0] den,
    // answer
    output logic              busy,
    output logic              done,
    output logic [W-1:0]      quo
);
    import halt_pkg::*;

    logic [W:0]           rem_reg, rem_next;
    logic [W-1:0]         quo_reg, quo_next;
    logic [W-1:0]         den_reg, den_next;
    logic [W-1:0]         num_reg, num_next;
    logic [$clog2(W):0]   cnt_reg, cnt_next;
    logic                 busy_reg, busy_next;
    logic                 done_reg, done_next;
    logic [W:0]           trial;

    // -------------------------------------------------------------------
    // one quotient bit per cycle
    // -------------------------------------------------------------------
    always_comb
    begin
        rem_next  = rem_reg;
        quo_next  = quo_reg;
        den_next  = den_reg;
        num_next  = num_reg;
        cnt_next  = cnt_reg;
        busy_next = busy_reg;
        done_next = 1'b0;
        trial     = {rem_reg[W-1:0], quo_reg[W-1]};
        if (busy_reg)
        begin
            quo_next = {quo_reg[W-2:0], 1'b0};
            if (trial >= {1'b0, den_reg})
            begin
                rem_next    = trial - {1'b0, den_reg};
                quo_next[0] = 1'b1;
            end
            else
                rem_next = trial;
            cnt_next = cnt_reg - 1'b1;
            if (cnt_reg == 1)
            begin
                busy_next = 1'b0;
                done_next = 1'b1;
            end
        end
        else if (start)
        begin
            rem_next  = '0;
            quo_next  = num;
            den_next  = den;
            num_next  = num;
            cnt_next  = ($clog2(W)+1)'(W);
            busy_next = 1'b1;
        end
    end

    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            rem_reg  <= '0;
            quo_reg  <= '0;
            den_reg  <= '0;
            num_reg  <= '0;
            cnt_reg  <= '0;
            busy_reg <= 1'b0;
            done_reg <= 1'b0;
        end
        else
        begin
            rem_reg  <= rem_next;
            quo_reg  <= quo_next;
            den_reg  <= den_next;
            num_reg  <= num_next;
            cnt_reg  <= cnt_next;
            busy_reg <= busy_next;
            done_reg <= done_next;
        end
    end

    assign busy = busy_reg;
    assign done = done_reg;
    assign quo  = quo_reg;

    // -------------------------------------------------------------------
    // checks
    // -------------------------------------------------------------------
    quotient_exact_a: assert property (
        @(posedge clock) disable iff (!rst_n)
        done_reg && den_reg != '0 |->
        ({{W{1'b0}}, quo_reg} * {{W{1'b0}}, den_reg} <= {{W{1'b0}}, num_reg})
        && ({{W{1'b0}}, num_reg} - {{W{1'b0}}, quo_reg} * {{W{1'b0}}, den_reg}
            < {{W{1'b0}}, den_reg}))
        else $error("divider quotient wrong");
endmodule // trim_div

/* hw/halt_trim_seq.sv */
// halt sequencer, done-job aging and trim length correction
`timescale 1ns/1ps
module halt_trim_seq
    import halt_pkg::*;
#(
    parameter int unsigned HALT_CYCLES = HALT_CYC,
    parameter int          JOBS        = 16
) (
    // clock and reset
    input  wire logic                       clock,
    input  wire logic                       rst_n,
    // machine
    input  wire logic                       run_contact,
    input  wire logic                       press_busy,
    input  wire logic                       material_moving,
    input  wire logic [halt_pkg::LEN_W-1:0] pos_count,
    input  wire logic [halt_pkg::LEN_W-1:0] target_len,
    output logic                            move_out,
    output logic                            fast_feed,
    output logic                            run_mode,
    output logic                            cut_fire,
    output logic [halt_pkg::LEN_W-1:0]      target_counts,
    // job aging
    input  wire logic                       day_tick,
    input  wire logic                       mem_test_start,
    input  wire logic                       job_done_set,
    input  wire logic [$clog2(JOBS)-1:0]    job_idx,
    input  wire logic [halt_pkg::AGE_W-1:0] auto_delete_days,
    output logic [JOBS-1:0]                 job_done,
    output logic                            sweep_busy,
    // trim correction
    input  wire logic                       part_done,
    input  wire logic [halt_pkg::LEN_W-1:0] part_len,
    input  wire logic                       ref_len_wr,
    input  wire logic [halt_pkg::LEN_W-1:0] ref_len_in,
    input  wire logic                       calc_start,
    input  wire logic [halt_pkg::LEN_W-1:0] meas_len,
    input  wire logic                       accept,
    input  wire logic                       reject,
    output logic [halt_pkg::LEN_W-1:0]      ref_len,
    output logic [halt_pkg::PCT_W-1:0]      scale_pct,
    output logic [halt_pkg::PCT_W-1:0]      scale_pct_new,
    output logic                            offer_valid
);
    import halt_pkg::*;
    localparam int DW = LEN_W + PCT_W;
    localparam int IW = $clog2(JOBS);

    // -------------------------------------------------------------------
    // halt sequence
    // -------------------------------------------------------------------
    seq_state_t         state_reg, state_next;
    logic [TMR_W-1:0]   tmr_reg, tmr_next;
    logic               move_reg, move_next;
    logic               runm_reg, runm_next;
    logic               cut_reg, cut_next;
    logic               armed_reg, armed_next;
    logic [LEN_W-1:0]   tgt_reg, tgt_next;
    logic [DW-1:0]      tgt_prod;

    always_comb
    begin
        state_next = state_reg;
        tmr_next   = tmr_reg;
        unique case (state_reg)
            ST_IDLE:
                if (run_contact)
                    state_next = ST_RUN;
            ST_RUN:
                if (!run_contact)
                begin
                    if (press_busy)
                        state_next = ST_PRESS;
                    else
                    begin
                        state_next = ST_DECEL;
                        tmr_next   = TMR_W'(HALT_CYCLES - 1);
                    end
                end
            ST_PRESS:
                if (!press_busy)
                begin
                    state_next = ST_DECEL;
                    tmr_next   = TMR_W'(HALT_CYCLES - 1);
                end
            ST_DECEL:
                if (!material_moving || tmr_reg == '0)
                    state_next = ST_IDLE;
                else
                    tmr_next = tmr_reg - 1'b1;
        endcase
        move_next = (state_next == ST_RUN) || (state_next == ST_PRESS);
        runm_next = (state_next != ST_IDLE);
        // cut stays live through decel
        cut_next = runm_reg && armed_reg && !press_busy && tgt_reg != '0
                   && pos_count >= tgt_reg;
        if (cut_next)
            armed_next = 1'b0;
        else if (pos_count < tgt_reg)
            armed_next = 1'b1;
        else
            armed_next = armed_reg;
        // factor scales the target in wheel counts
        tgt_prod = target_len * scale_pct;
        tgt_next = LEN_W'(tgt_prod / DW'(SCALE_UNITY));
    end

    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            state_reg <= ST_IDLE;
            tmr_reg   <= '0;
            move_reg  <= 1'b0;
            runm_reg  <= 1'b0;
            cut_reg   <= 1'b0;
            armed_reg <= 1'b1;
            tgt_reg   <= '0;
        end
        else
        begin
            state_reg <= state_next;
            tmr_reg   <= tmr_next;
            move_reg  <= move_next;
            runm_reg  <= runm_next;
            cut_reg   <= cut_next;
            armed_reg <= armed_next;
            tgt_reg   <= tgt_next;
        end
    end

    assign move_out      = move_reg;
    assign fast_feed     = move_reg;
    assign run_mode      = runm_reg;
    assign cut_fire      = cut_reg;
    assign target_counts = tgt_reg;

    // -------------------------------------------------------------------
    // done-job aging and erase sweep
    // -------------------------------------------------------------------
    logic [JOBS-1:0]    done_reg, done_next;
    logic [AGE_W-1:0]   age_reg [JOBS];
    logic [AGE_W-1:0]   age_next [JOBS];
    logic               sweep_reg, sweep_next;
    logic [IW-1:0]      sidx_reg, sidx_next;

    always_comb
    begin
        done_next  = done_reg;
        age_next   = age_reg;
        sweep_next = sweep_reg;
        sidx_next  = sidx_reg;
        if (day_tick)
            for (int i = 0; i < JOBS; i++)
                if (done_reg[i] && age_reg[i] != '1)
                    age_next[i] = age_reg[i] + 1'b1;
        if (sweep_reg)
        begin
            if (done_reg[sidx_reg] && age_reg[sidx_reg] >= auto_delete_days)
                done_next[sidx_reg] = 1'b0;
            sidx_next = sidx_reg + 1'b1;
            if (sidx_reg == IW'(JOBS - 1))
                sweep_next = 1'b0;
        end
        else if (mem_test_start)
        begin
            sweep_next = 1'b1;
            sidx_next  = '0;
        end
        // a fresh completion beats the erase
        if (job_done_set)
        begin
            done_next[job_idx] = 1'b1;
            age_next[job_idx]  = '0;
        end
    end

    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            done_reg  <= '0;
            for (int i = 0; i < JOBS; i++)
                age_reg[i] <= '0;
            sweep_reg <= 1'b1; // power-up test sweep
            sidx_reg  <= '0;
        end
        else
        begin
            done_reg  <= done_next;
            age_reg   <= age_next;
            sweep_reg <= sweep_next;
            sidx_reg  <= sidx_next;
        end
    end

    assign job_done   = done_reg;
    assign sweep_busy = sweep_reg;

    // -------------------------------------------------------------------
    // trim correction
    // -------------------------------------------------------------------
    logic [LEN_W-1:0]   ref_reg, ref_next;
    logic [PCT_W-1:0]   scale_reg, scale_next;
    logic [PCT_W-1:0]   prop_reg, prop_next;
    logic               offer_reg, offer_next;
    logic               div_start;
    logic               div_busy;
    logic               div_done;
    logic [DW-1:0]      div_num;
    logic [DW-1:0]      div_quo;

    always_comb
    begin
        ref_next   = ref_reg;
        scale_next = scale_reg;
        prop_next  = prop_reg;
        offer_next = offer_reg;
        div_start  = calc_start && !div_busy && meas_len != '0;
        // half the divisor added rounds to 0.001 percent
        div_num = ref_reg * scale_reg + DW'(meas_len >> 1);
        if (ref_len_wr)
            ref_next = ref_len_in;
        else if (part_done)
            ref_next = part_len;
        if (div_done)
        begin
            prop_next  = (div_quo[DW-1:PCT_W] != '0) ? '1
                                                     : div_quo[PCT_W-1:0];
            offer_next = 1'b1;
        end
        else if (offer_reg && accept)
        begin
            scale_next = prop_reg;
            offer_next = 1'b0;
        end
        else if (offer_reg && reject)
            offer_next = 1'b0;
    end

    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            ref_reg   <= '0;
            scale_reg <= SCALE_UNITY;
            prop_reg  <= SCALE_UNITY;
            offer_reg <= 1'b0;
        end
        else
        begin
            ref_reg   <= ref_next;
            scale_reg <= scale_next;
            prop_reg  <= prop_next;
            offer_reg <= offer_next;
        end
    end

    trim_div #(.W(DW)) u_div (
        .clock (clock),
        .rst_n (rst_n),
        .start (div_start),
        .num   (div_num),
        .den   (DW'(meas_len)),
        .busy  (div_busy),
        .done  (div_done),
        .quo   (div_quo)
    );

    assign ref_len       = ref_reg;
    assign scale_pct     = scale_reg;
    assign scale_pct_new = prop_reg;
    assign offer_valid   = offer_reg;

    // -------------------------------------------------------------------
    // checks
    // -------------------------------------------------------------------
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_n);

    move_drop_a: assert property (
        state_reg == ST_RUN && !run_contact && !press_busy
        |=> !move_out && !fast_feed && run_mode)
        else $error("movement not dropped on halt");
    decel_hold_a: assert property (
        state_reg == ST_DECEL && material_moving && tmr_reg != '0
        |=> run_mode)
        else $error("run mode lost during decel");
    decel_end_a: assert property (
        state_reg == ST_DECEL && (!material_moving || tmr_reg == '0)
        |=> !run_mode && !move_out)
        else $error("run mode held after stop");
    press_hold_a: assert property (
        (state_reg == ST_RUN || state_reg == ST_PRESS) && !run_contact
        && press_busy |=> move_out && fast_feed)
        else $error("movement dropped during press");
    decel_cut_a: assert property (
        run_mode && armed_reg && !press_busy && tgt_reg != '0
        && pos_count >= tgt_reg |=> cut_fire ##1 !cut_fire)
        else $error("automatic cut missed");
    aged_erase_a: assert property (
        sweep_reg && done_reg[sidx_reg]
        && age_reg[sidx_reg] >= auto_delete_days
        && !(job_done_set && job_idx == sidx_reg)
        |=> !done_reg[$past(sidx_reg)])
        else $error("aged done job not erased");
    unity_scale_a: assert property (
        scale_reg == SCALE_UNITY && $stable(scale_reg)
        |=> target_counts == $past(target_len))
        else $error("unity factor changed length");
    ref_follow_a: assert property (
        part_done && !ref_len_wr |=> ref_len == $past(part_len))
        else $error("reference not last part");
    accept_a: assert property (
        offer_reg && accept && !div_done
        |=> scale_pct == $past(prop_reg) && !offer_valid)
        else $error("accept did not load factor");
    reject_a: assert property (
        offer_reg && reject && !accept && !div_done
        |=> $stable(scale_pct) && !offer_valid)
        else $error("reject changed factor");

    decel_timeout_c: cover property (
        state_reg == ST_DECEL && material_moving && tmr_reg == '0);
    decel_cut_c: cover property (state_reg == ST_DECEL && cut_reg);
    press_halt_c: cover property (
        state_reg == ST_PRESS ##1 state_reg == ST_DECEL);
    factor_accept_c: cover property (offer_reg && accept);
endmodule // halt_trim_seq

/* bench/machine_model.sv */
// feed drive, shear press and measuring wheel model
`timescale 1ns/1ps
module machine_model
    import halt_pkg::*;
(
    // clock and reset
    input  wire logic                       clock,
    input  wire logic                       rst_n,
    // from the sequencer
    input  wire logic                       fast_feed,
    input  wire logic                       cut_fire,
    // bench controls
    input  wire logic                       press_trig,
    input  wire logic [15:0]                press_len,
    input  wire logic [15:0]                decel_len,
    // to the sequencer
    output logic                            press_busy,
    output logic                            material_moving,
    output logic [halt_pkg::LEN_W-1:0]      pos_count
);
    logic [15:0] press_cnt;
    logic [15:0] coast_cnt;

    // -------------------------------------------------------------------
    // feed, wheel and press
    // -------------------------------------------------------------------
    assign material_moving = (coast_cnt != 16'h0000);
    assign press_busy      = (press_cnt != 16'h0000);

    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            press_cnt <= 16'h0000;
            coast_cnt <= 16'h0000;
            pos_count <= 24'h000000;
        end
        else
        begin
            // drive hangs on fast feed, coasts after it drops
            if (fast_feed)
                coast_cnt <= decel_len;
            else if (coast_cnt != 16'h0000)
                coast_cnt <= coast_cnt - 16'h0001;
            if (cut_fire)
                pos_count <= 24'h000000;
            else if (material_moving)
                pos_count <= pos_count + 24'h000001;
            if (cut_fire || press_trig)
                press_cnt <= press_len;
            else if (press_cnt != 16'h0000)
                press_cnt <= press_cnt - 16'h0001;
        end
    end
endmodule // machine_model

/* bench/tb_top.sv */
// self-checking bench for the halt sequencer and trim correction
`timescale 1ns/1ps
module tb_top;
    import halt_pkg::*;
    localparam int HC = 200;
    localparam int NJ = 16;
    logic        clock, rst_n, run_contact, press_busy, material_moving;
    logic        move_out, fast_feed, run_mode, cut_fire, day_tick;
    logic        mem_test_start, job_done_set, sweep_busy, part_done;
    logic        ref_len_wr, calc_start, accept, reject, offer_valid;
    logic        press_trig, offer_prev;
    logic [23:0] pos_count, target_len, target_counts, part_len, ref_len_in;
    logic [23:0] meas_len, ref_len, scale_pct, scale_pct_new;
    logic [15:0] press_len, decel_len, job_done;
    logic [3:0]  job_idx;
    logic [7:0]  auto_delete_days;
    logic [23:0] exp_q[$];
    int          miscompares, num_checks, decel_cuts, cyc;

    always #4 clock = ~clock;

    halt_trim_seq #(.HALT_CYCLES(HC), .JOBS(NJ)) DUT (
        .clock(clock), .rst_n(rst_n), .run_contact(run_contact),
        .press_busy(press_busy), .material_moving(material_moving),
        .pos_count(pos_count), .target_len(target_len),
        .move_out(move_out), .fast_feed(fast_feed), .run_mode(run_mode),
        .cut_fire(cut_fire), .target_counts(target_counts),
        .day_tick(day_tick), .mem_test_start(mem_test_start),
        .job_done_set(job_done_set), .job_idx(job_idx),
        .auto_delete_days(auto_delete_days), .job_done(job_done),
        .sweep_busy(sweep_busy), .part_done(part_done),
        .part_len(part_len), .ref_len_wr(ref_len_wr),
        .ref_len_in(ref_len_in), .calc_start(calc_start),
        .meas_len(meas_len), .accept(accept), .reject(reject),
        .ref_len(ref_len), .scale_pct(scale_pct),
        .scale_pct_new(scale_pct_new), .offer_valid(offer_valid));

    machine_model u_machine (
        .clock(clock), .rst_n(rst_n), .fast_feed(fast_feed),
        .cut_fire(cut_fire), .press_trig(press_trig),
        .press_len(press_len), .decel_len(decel_len),
        .press_busy(press_busy), .material_moving(material_moving),
        .pos_count(pos_count));

    // -------------------------------------------------------------------
    // compare and helper tasks
    // -------------------------------------------------------------------
    task automatic print_verdict();
        if (miscompares == 0 && num_checks > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    task automatic chk_val(input logic [23:0] got, input logic [23:0] exp);
        num_checks++;
        if (got !== exp)
        begin
            miscompares++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic chk_bit(input logic got, input logic exp);
        chk_val({23'h0, got}, {23'h0, exp});
    endtask

    task automatic chk_rng(input int got, input int lo, input int hi);
        num_checks++;
        if (got < lo || got > hi)
        begin
            miscompares++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, lo);
        end
    endtask

    task automatic wait_for(ref logic s, input logic v, input int lim,
                            output int n);
        n = 0;
        while (s !== v && n < lim)
        begin
            @(negedge clock);
            n++;
        end
        chk_bit(s, v);
    endtask

    function automatic logic [23:0] exp_scale(logic [23:0] r, logic [23:0] o,
                                              logic [23:0] m);
        logic [47:0] q;
        q = ({24'h0, r} * {24'h0, o} + {25'h0, m[23:1]}) / {24'h0, m};
        return (q > 48'h000000FFFFFF) ? 24'hFFFFFF : q[23:0];
    endfunction

    task automatic run_start();
        int n;
        @(posedge clock);
        run_contact <= 1'b1;
        wait_for(move_out, 1'b1, 4, n);
        chk_bit(fast_feed, 1'b1);
        chk_bit(run_mode, 1'b1);
    endtask

    task automatic tick();
        @(posedge clock);
        day_tick <= 1'b1;
        @(posedge clock);
        day_tick <= 1'b0;
    endtask

    task automatic set_job(input logic [3:0] idx);
        @(posedge clock);
        job_done_set <= 1'b1;
        job_idx      <= idx;
        @(posedge clock);
        job_done_set <= 1'b0;
    endtask

    // -------------------------------------------------------------------
    // output watcher and timeout
    // -------------------------------------------------------------------
    always @(negedge clock)
    begin
        if (offer_valid === 1'b1 && !offer_prev)
        begin
            if (exp_q.size() == 0)
                chk_val(scale_pct_new, 24'h000000);
            else
                chk_val(scale_pct_new, exp_q.pop_front());
        end
        offer_prev = (offer_valid === 1'b1);
        if (cut_fire === 1'b1 && run_mode === 1'b1 && move_out === 1'b0)
            decel_cuts++;
        cyc++;
        if (cyc > 40000)
        begin
            miscompares++;
            print_verdict();
        end
    end

    // -------------------------------------------------------------------
    // main sequence
    // -------------------------------------------------------------------
    initial
    begin
        int          n;
        logic [23:0] r, m, nw, old, t;
        {clock, rst_n, run_contact, day_tick, mem_test_start} = 5'h00;
        {job_done_set, part_done, ref_len_wr, calc_start} = 4'h0;
        {accept, reject, press_trig, offer_prev} = 4'h0;
        {part_len, ref_len_in, meas_len} = 72'h0;
        target_len = 24'hFFFFFF;
        job_idx = 4'h0;
        auto_delete_days = 8'h03;
        press_len = 16'h0005;
        decel_len = 16'h000A;
        {miscompares, num_checks, decel_cuts, cyc} = 128'h0;
        old = SCALE_UNITY;
        void'($urandom(32'h12CF95C9));
        repeat (12) @(posedge clock);
        rst_n <= 1'b1;
        @(negedge clock);
        chk_val(scale_pct, SCALE_UNITY);
        chk_val(scale_pct_new, SCALE_UNITY);
        chk_bit(offer_valid, 1'b0);
        wait_for(sweep_busy, 1'b0, NJ + 4, n);
        // job aging: job 3 ages to 3 days, job 5 to 1 day
        set_job(4'h3);
        repeat (2) tick();
        set_job(4'h5);
        tick();
        @(negedge clock);
        chk_bit(job_done[3], 1'b1);
        @(posedge clock);
        mem_test_start <= 1'b1;
        @(posedge clock);
        mem_test_start <= 1'b0;
        @(negedge clock);
        wait_for(sweep_busy, 1'b0, NJ + 4, n);
        chk_bit(job_done[3], 1'b0);
        chk_bit(job_done[5], 1'b1);
        // plain halt, motion stops before the timeout
        run_start();
        repeat (20) @(posedge clock);
        run_contact <= 1'b0;
        repeat (2) @(negedge clock);
        chk_bit(move_out, 1'b0);
        chk_bit(run_mode, 1'b1);
        wait_for(run_mode, 1'b0, 30, n);
        chk_rng(n, 8, 14);
        // halt with a press cycle under way
        run_start();
        @(posedge clock);
        press_trig <= 1'b1;
        press_len  <= 16'h0014;
        @(posedge clock);
        press_trig <= 1'b0;
        run_contact <= 1'b0;
        repeat (10) @(negedge clock);
        chk_bit(move_out, 1'b1);
        wait_for(move_out, 1'b0, 20, n);
        chk_bit(press_busy, 1'b0);
        wait_for(run_mode, 1'b0, 30, n);
        // long coast, timeout ends run mode
        decel_len <= 16'h03E8;
        run_start();
        @(posedge clock);
        run_contact <= 1'b0;
        @(negedge clock);
        wait_for(run_mode, 1'b0, HC + 20, n);
        chk_rng(n, HC - 4, HC + 6);
        chk_bit(material_moving, 1'b1);
        wait_for(material_moving, 1'b0, 1100, n);
        // automatic cuts while decelerating
        @(posedge clock);
        target_len <= 24'h000040;
        press_len  <= 16'h0005;
        decel_len  <= 16'h0096;
        run_start();
        repeat (300) @(posedge clock);
        run_contact <= 1'b0;
        @(negedge clock);
        wait_for(run_mode, 1'b0, HC + 20, n);
        chk_rng(decel_cuts, 1, 10);
        // trim correction, reject on even passes and accept on odd
        for (int i = 0; i < 4; i++)
        begin
            r = 24'h010000 + 24'($urandom % 32'h10000);
            m = r - 24'h000800 + 24'($urandom % 32'h1000);
            @(posedge clock);
            if (i[0])
            begin
                ref_len_wr <= 1'b1;
                ref_len_in <= r;
            end
            else
            begin
                part_done <= 1'b1;
                part_len  <= r;
            end
            @(posedge clock);
            {ref_len_wr, part_done} <= 2'b00;
            @(negedge clock);
            chk_val(ref_len, r);
            nw = exp_scale(r, old, m);
            exp_q.push_back(nw);
            @(posedge clock);
            calc_start <= 1'b1;
            meas_len   <= m;
            @(posedge clock);
            calc_start <= 1'b0;
            @(negedge clock);
            wait_for(offer_valid, 1'b1, 60, n);
            chk_rng(n, 45, 55);
            chk_val(scale_pct, old);
            @(posedge clock);
            if (i[0])
                accept <= 1'b1;
            else
                reject <= 1'b1;
            @(posedge clock);
            {accept, reject} <= 2'b00;
            if (i[0])
                old = nw;
            repeat (2) @(negedge clock);
            chk_val(scale_pct, old);
            chk_bit(offer_valid, 1'b0);
            t = 24'($urandom % 32'h100000);
            @(posedge clock);
            target_len <= t;
            repeat (3) @(negedge clock);
            chk_val(target_counts, 24'(({24'h0, t} * {24'h0, old})
                                   / {24'h0, SCALE_UNITY}));
        end
        print_verdict();
    end
endmodule // tb_top
